// ===== design/tie_regs.svh
// register offsets, field positions and reset values of the
// interrupt-enable set/clear pair and its flag register.
// assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef TIE_REGS_SVH
`define TIE_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define TIE_CLR_OFS 8'h24
`define TIE_SET_OFS 8'h28
`define TIE_FLAG_OFS 8'h2c

// ----------------------------------------
// fields
// ----------------------------------------
`define TIE_OVF_BIT 0
`define TIE_TRG_BIT 1
`define TIE_CNT_BIT 2
`define TIE_ERR_BIT 3
`define TIE_UPD_BIT 10
`define TIE_DBG_BIT 11
`define TIE_SOFTA_BIT 12
`define TIE_SOFTB_BIT 13
`define TIE_HARD0_BIT 14
`define TIE_HARD1_BIT 15
`define TIE_CH_LO 16
`define TIE_CH_HI 19
`define TIE_VALID_MASK 24'h0ffc0f
`define TIE_RESET_VAL 24'h000000

`endif

// ===== design/tie_pkg.sv
// types shared by the interrupt-enable register bank.
// assumes tie_regs.svh sits on the include path.
package tie_pkg;

	// ----------------------------------------
	// bus phase and state image
	// ----------------------------------------
	typedef enum logic {
		ph_idle,
		ph_ack
	} phase_t;

	typedef struct packed {
		phase_t phase;
		logic waitreq;
		logic [31:0] rdata;
		logic [23:0] enable;
		logic [23:0] flags;
		logic irq;
	} state_t;

endpackage

// ===== design/timer_irq_enable_set_clear.sv
// interrupt-enable set/clear register pair with flag register and
// one level interrupt, reached over Avalon-MM with waitrequest.
// assumes event inputs are one-cycle pulses synchronous to clk.
//
// Functional notes
// - set view enables sources, no read-modify-write
// - set and clear views share enable bits
// - set view at 0x28, resets to zero
// - writing zero leaves enable bits unchanged
// - clear bit 1 disables retrigger
// - clear bit 0 disables overflow
// - clear bits 19:16 disable channels 3:0
// - clear bits 15:14 disable hard trips
// - set bits 13:12 enable soft trips
// - set bit 11 enables debug trip state
// - set bit 10 enables update trip
// - set bit 3 enables capture error
// - set bit 2 enables counter event
// - set bit 1 enables retrigger
// - set bit 0 enables overflow
// - set bits 19:16 enable channels 3:0
// - set bits 15:14 enable hard trips
// - clear view at 0x24, clears remaining bits
`timescale 1ns/1ns
`include "tie_regs.svh"

module timer_irq_enable_set_clear
	import tie_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic peripheral_write_protect,
	input wire logic [23:0] event_pulse,
	output logic [23:0] irq_enable,
	output logic irq
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		logic [31:0] m;
		m = 32'h00000000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] ofs);
		return a == ofs;
	endfunction

	state_t cur_reg;
	state_t cur_next;
	logic req;
	logic accept;
	logic [23:0] wbits;
	logic set_wr;
	logic clr_wr;
	logic flag_wr;
	logic [31:0] lanes;
	logic [23:0] set_bits;
	logic [23:0] clr_bits;

	assign req = read | write;
	// the transfer completes in the ack cycle, when waitrequest is low
	assign accept = req & (cur_reg.phase == ph_ack);
	// only the implemented bits can be touched; byte lanes gate data
	// the byte mask sits on its own net so that it can be sliced
	assign lanes = lane_mask(byteenable);
	assign wbits = writedata[23:0] & lanes[23:0] & `TIE_VALID_MASK;
	// write protection blocks both enable views, not the flags
	assign set_wr = accept & write & ~peripheral_write_protect &
		hit(address, `TIE_SET_OFS);
	assign clr_wr = accept & write & ~peripheral_write_protect &
		hit(address, `TIE_CLR_OFS);
	assign flag_wr = accept & write & hit(address, `TIE_FLAG_OFS);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		cur_next = cur_reg;
		case (cur_reg.phase)
			ph_idle: begin
				if (req) begin
					cur_next.phase = ph_ack;
					cur_next.waitreq = 1'b0;
					cur_next.rdata = 32'h00000000;
					if (read && (hit(address, `TIE_SET_OFS) ||
						hit(address, `TIE_CLR_OFS))) begin
						cur_next.rdata = {8'h00, cur_reg.enable};
					end else if (read &&
						hit(address, `TIE_FLAG_OFS)) begin
						cur_next.rdata = {8'h00, cur_reg.flags};
					end
				end
			end
			ph_ack: begin
				cur_next.phase = ph_idle;
				cur_next.waitreq = 1'b1;
			end
			default: begin
				cur_next.phase = ph_idle;
				cur_next.waitreq = 1'b1;
			end
		endcase
		// each source decoded on its own so a field can be traced
		set_bits = 24'h000000;
		clr_bits = 24'h000000;
		if (set_wr) begin
			set_bits[`TIE_OVF_BIT] = wbits[`TIE_OVF_BIT];
			set_bits[`TIE_TRG_BIT] = wbits[`TIE_TRG_BIT];
			set_bits[`TIE_CNT_BIT] = wbits[`TIE_CNT_BIT];
			set_bits[`TIE_ERR_BIT] = wbits[`TIE_ERR_BIT];
			set_bits[`TIE_UPD_BIT] = wbits[`TIE_UPD_BIT];
			set_bits[`TIE_DBG_BIT] = wbits[`TIE_DBG_BIT];
			set_bits[`TIE_SOFTB_BIT:`TIE_SOFTA_BIT] =
				wbits[`TIE_SOFTB_BIT:`TIE_SOFTA_BIT];
			set_bits[`TIE_HARD1_BIT:`TIE_HARD0_BIT] =
				wbits[`TIE_HARD1_BIT:`TIE_HARD0_BIT];
			set_bits[`TIE_CH_HI:`TIE_CH_LO] =
				wbits[`TIE_CH_HI:`TIE_CH_LO];
		end
		// one write reaches one view, so set and clear never collide
		if (clr_wr) begin
			clr_bits[`TIE_OVF_BIT] = wbits[`TIE_OVF_BIT];
			clr_bits[`TIE_TRG_BIT] = wbits[`TIE_TRG_BIT];
			clr_bits[`TIE_CNT_BIT] = wbits[`TIE_CNT_BIT];
			clr_bits[`TIE_ERR_BIT] = wbits[`TIE_ERR_BIT];
			clr_bits[`TIE_UPD_BIT] = wbits[`TIE_UPD_BIT];
			clr_bits[`TIE_DBG_BIT] = wbits[`TIE_DBG_BIT];
			clr_bits[`TIE_SOFTB_BIT:`TIE_SOFTA_BIT] =
				wbits[`TIE_SOFTB_BIT:`TIE_SOFTA_BIT];
			clr_bits[`TIE_HARD1_BIT:`TIE_HARD0_BIT] =
				wbits[`TIE_HARD1_BIT:`TIE_HARD0_BIT];
			clr_bits[`TIE_CH_HI:`TIE_CH_LO] =
				wbits[`TIE_CH_HI:`TIE_CH_LO];
		end
		// ones set in the set view, clear in the clear view; zeros leave the bit alone
		cur_next.enable = (cur_reg.enable | set_bits) & ~clr_bits;
		// a new event beats a software clear in the same cycle
		cur_next.flags = (cur_reg.flags & ~(flag_wr ? wbits : 24'h0)) |
			(event_pulse & `TIE_VALID_MASK);
		cur_next.irq = |(cur_next.flags & cur_next.enable);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur_reg.phase <= ph_idle;
			cur_reg.waitreq <= 1'b1;
			cur_reg.rdata <= 32'h00000000;
			cur_reg.enable <= `TIE_RESET_VAL;
			cur_reg.flags <= `TIE_RESET_VAL;
			cur_reg.irq <= 1'b0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign readdata = cur_reg.rdata;
	assign waitrequest = cur_reg.waitreq;
	assign irq_enable = cur_reg.enable;
	assign irq = cur_reg.irq;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic full_wr;
	assign full_wr = byteenable == 4'hf;

	set_view_any_a: assert property (
		set_wr && full_wr |=>
		irq_enable == ($past(irq_enable) |
		($past(writedata[23:0]) & `TIE_VALID_MASK)))
		else $error("set view write did not or in the data");

	view_alias_a: assert property (
		read && !waitrequest && hit(address, `TIE_CLR_OFS) |->
		readdata[23:0] == irq_enable)
		else $error("clear view read differs from enables");

	set_read_a: assert property (
		read && !waitrequest && hit(address, `TIE_SET_OFS) |->
		readdata == {8'h00, irq_enable})
		else $error("set view read differs from enables");

	zero_write_a: assert property (
		(set_wr || clr_wr) && writedata[23:0] == 24'h0 |=>
		$stable(irq_enable))
		else $error("zero write changed an enable");

	clear_trg_a: assert property (
		clr_wr && byteenable[0] && writedata[`TIE_TRG_BIT] |=>
		!irq_enable[`TIE_TRG_BIT])
		else $error("retrigger enable not cleared");

	clear_ovf_a: assert property (
		clr_wr && byteenable[0] && writedata[`TIE_OVF_BIT] |=>
		!irq_enable[`TIE_OVF_BIT])
		else $error("overflow enable not cleared");

	clear_chan_a: assert property (
		clr_wr && byteenable[2] |=>
		(irq_enable[`TIE_CH_HI:`TIE_CH_LO] &
		$past(writedata[`TIE_CH_HI:`TIE_CH_LO])) == 4'h0)
		else $error("channel enable not cleared");

	clear_hard_a: assert property (
		clr_wr && byteenable[1] |=>
		(irq_enable[`TIE_HARD1_BIT:`TIE_HARD0_BIT] &
		$past(writedata[`TIE_HARD1_BIT:`TIE_HARD0_BIT])) == 2'b00)
		else $error("hard trip enable not cleared");

	set_soft_a: assert property (
		set_wr && byteenable[1] |=>
		(~irq_enable[`TIE_SOFTB_BIT:`TIE_SOFTA_BIT] &
		$past(writedata[`TIE_SOFTB_BIT:`TIE_SOFTA_BIT])) == 2'b00)
		else $error("soft trip enable not set");

	set_dbg_a: assert property (
		set_wr && byteenable[1] && writedata[`TIE_DBG_BIT] |=>
		irq_enable[`TIE_DBG_BIT])
		else $error("debug trip enable not set");

	set_upd_a: assert property (
		set_wr && byteenable[1] && writedata[`TIE_UPD_BIT] |=>
		irq_enable[`TIE_UPD_BIT])
		else $error("update trip enable not set");

	set_err_a: assert property (
		set_wr && byteenable[0] && writedata[`TIE_ERR_BIT] |=>
		irq_enable[`TIE_ERR_BIT])
		else $error("capture error enable not set");

	set_cnt_only_a: assert property (
		set_wr && full_wr && writedata[23:0] == 24'h000004 |=>
		irq_enable[`TIE_CNT_BIT] &&
		irq_enable[`TIE_TRG_BIT] == $past(irq_enable[`TIE_TRG_BIT]))
		else $error("counter enable set wrong or touched retrigger");

	set_trg_a: assert property (
		set_wr && byteenable[0] && writedata[`TIE_TRG_BIT] |=>
		irq_enable[`TIE_TRG_BIT])
		else $error("retrigger enable not set");

	set_ovf_a: assert property (
		set_wr && byteenable[0] && writedata[`TIE_OVF_BIT] |=>
		irq_enable[`TIE_OVF_BIT])
		else $error("overflow enable not set");

	set_chan_a: assert property (
		set_wr && byteenable[2] |=>
		(~irq_enable[`TIE_CH_HI:`TIE_CH_LO] &
		$past(writedata[`TIE_CH_HI:`TIE_CH_LO])) == 4'h0)
		else $error("channel enable not set");

	set_hard_a: assert property (
		set_wr && byteenable[1] |=>
		(~irq_enable[`TIE_HARD1_BIT:`TIE_HARD0_BIT] &
		$past(writedata[`TIE_HARD1_BIT:`TIE_HARD0_BIT])) == 2'b00)
		else $error("hard trip enable not set");

	clear_rest_a: assert property (
		clr_wr && full_wr |=>
		(irq_enable & $past(writedata[23:0])) == 24'h0)
		else $error("clear view left a bit set");

	clear_cnt_a: assert property (
		clr_wr && byteenable[0] && writedata[`TIE_CNT_BIT] |=>
		!irq_enable[`TIE_CNT_BIT])
		else $error("counter enable not cleared");

	clear_err_a: assert property (
		clr_wr && byteenable[0] && writedata[`TIE_ERR_BIT] |=>
		!irq_enable[`TIE_ERR_BIT])
		else $error("capture error enable not cleared");

	clear_soft_a: assert property (
		clr_wr && byteenable[1] |=>
		(irq_enable[`TIE_SOFTB_BIT:`TIE_SOFTA_BIT] &
		$past(writedata[`TIE_SOFTB_BIT:`TIE_SOFTA_BIT])) == 2'b00)
		else $error("soft trip enable not cleared");

	clear_dbg_upd_a: assert property (
		clr_wr && byteenable[1] |=>
		(irq_enable[`TIE_DBG_BIT:`TIE_UPD_BIT] &
		$past(writedata[`TIE_DBG_BIT:`TIE_UPD_BIT])) == 2'b00)
		else $error("debug or update trip enable not cleared");

	set_no_clear_a: assert property (
		set_wr |=> (~irq_enable & $past(irq_enable)) == 24'h000000)
		else $error("set view write cleared an enable");

	clear_no_set_a: assert property (
		clr_wr |=> (irq_enable & ~$past(irq_enable)) == 24'h000000)
		else $error("clear view write set an enable");

	reset_clean_a: assert property (
		$fell(rst) |-> irq_enable == `TIE_RESET_VAL && !irq &&
		waitrequest && readdata == 32'h00000000)
		else $error("state not cleared by reset");

	irq_needs_enable_a: assert property (
		irq_enable == 24'h000000 |-> !irq)
		else $error("interrupt raised with no enable");

	irq_level_a: assert property (
		##1 irq == |(cur_reg.flags & irq_enable))
		else $error("interrupt does not match flags and enables");

	event_wins_a: assert property (
		flag_wr && event_pulse[`TIE_OVF_BIT] |=>
		cur_reg.flags[`TIE_OVF_BIT])
		else $error("event lost against flag clear");

	ack_one_cycle_a: assert property (
		req && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("waitrequest not low for exactly one cycle");

	protect_hold_a: assert property (
		accept && write && peripheral_write_protect &&
		!hit(address, `TIE_FLAG_OFS) |=> $stable(irq_enable))
		else $error("protected write changed enables");

	enable_hold_a: assert property (
		!set_wr && !clr_wr |=> $stable(irq_enable))
		else $error("enables changed without a write");

	reserved_zero_a: assert property (
		(irq_enable & ~`TIE_VALID_MASK) == 24'h000000)
		else $error("reserved enable bit set");

	flag_set_a: assert property (
		|(event_pulse & `TIE_VALID_MASK) |=>
		(cur_reg.flags & $past(event_pulse & `TIE_VALID_MASK)) ==
		$past(event_pulse & `TIE_VALID_MASK))
		else $error("event did not set its flag");

	flag_clear_a: assert property (
		flag_wr && !(|event_pulse) |=>
		(cur_reg.flags & $past(wbits)) == 24'h000000)
		else $error("flag not cleared by a one");

	unmapped_zero_a: assert property (
		read && !waitrequest && !hit(address, `TIE_SET_OFS) &&
		!hit(address, `TIE_CLR_OFS) && !hit(address, `TIE_FLAG_OFS)
		|-> readdata == 32'h00000000)
		else $error("unmapped read returned data");

	wait_idle_a: assert property (
		!req && waitrequest |=> waitrequest)
		else $error("waitrequest dropped with no request");

	// ----------------------------------------
	// covers
	// ----------------------------------------
	set_then_clear_c: cover property (set_wr ##[1:20] clr_wr);
	irq_raise_c: cover property (!irq ##1 irq);
	event_clear_c: cover property (flag_wr && |event_pulse);
	protect_c: cover property (accept && write &&
		peripheral_write_protect);
	chan_irq_c: cover property (irq && irq_enable[`TIE_CH_LO]);

endmodule

// ===== tb/timer_irq_enable_set_clear_bench.sv
// self-checking bench for the interrupt-enable set/clear bank.
// assumes the design files and tie_regs.svh are on the include path.
`timescale 1ns/1ns

module timer_irq_enable_set_clear_bench import tie_pkg::*;;
	logic clk, rst, read, write, peripheral_write_protect, irq;
	logic waitrequest;
	logic [7:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata;
	logic [23:0] event_pulse, irq_enable, exp;
	int num_errors = 0;
	int n_checks = 0;
	int cycles = 0;

	timer_irq_enable_set_clear timer_irq_enable_set_clear_i (
		.clk(clk), .rst(rst), .address(address), .read(read),
		.write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.peripheral_write_protect(peripheral_write_protect),
		.event_pulse(event_pulse), .irq_enable(irq_enable), .irq(irq));

	// ----------------------------------------
	// clock, timeout, verdict
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// whole run is well under 2000 cycles; 4000 means a hang
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string s, input logic [31:0] seen,
		input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", s, want, seen);
		end
	endtask

	// ----------------------------------------
	// bus access
	// ----------------------------------------
	// leading edge keeps a release and the next request apart
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
		@(posedge clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= w;
		read <= !w;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hf, q);
	endtask

	task automatic rdc(input string s, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hf, q);
		check(s, q, e);
	endtask

	// port value one edge after the write took effect
	task automatic en_chk(input logic [23:0] e);
		@(posedge clk);
		check("irq_enable", {8'h0, irq_enable}, {8'h0, e});
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdc("set view", 8'h28, 32'h0);
		rdc("clear view", 8'h24, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
		check("irq_enable", {8'h0, irq_enable}, 32'h0);
	endtask

	// walks every bit, reserved ones included, up then down
	task automatic t_bits();
		logic [23:0] b;
		exp = 24'h0;
		for (int i = 0; i < 24; i++) begin
			b = 24'h1 << i;
			wr(8'h28, {8'h0, b});
			exp = exp | (b & 24'h0ffc0f);
			en_chk(exp);
			rdc("clear view", 8'h24, {8'h0, exp});
		end
		wr(8'h28, 32'h0);
		wr(8'h24, 32'h0);
		rdc("set view", 8'h28, 32'h000ffc0f);
		for (int i = 0; i < 24; i++) begin
			b = 24'h1 << i;
			wr(8'h24, {8'h0, b});
			exp = exp & ~b;
			rdc("set view", 8'h28, {8'h0, exp});
		end
	endtask

	task automatic t_bytes();
		logic [31:0] q;
		bus(1'b1, 8'h28, 32'hffffffff, 4'b0010, q);
		en_chk(24'h00fc00);
		bus(1'b1, 8'h28, 32'hffffffff, 4'b0100, q);
		bus(1'b1, 8'h24, 32'hffffffff, 4'b0010, q);
		rdc("clear view", 8'h24, 32'h000f0000);
		wr(8'h24, 32'hffffffff);
	endtask

	// overflow toggles the level while channel 0 is masked, then enabling channel 0 raises it
	task automatic t_irq();
		wr(8'h28, 32'h1);
		event_pulse <= 24'h010001;
		@(posedge clk);
		event_pulse <= 24'h0;
		@(posedge clk);
		check("irq", {31'h0, irq}, 32'h1);
		rdc("flags", 8'h2c, 32'h00010001);
		wr(8'h24, 32'h1);
		@(posedge clk);
		check("irq", {31'h0, irq}, 32'h0);
		wr(8'h28, 32'h1);
		@(posedge clk);
		check("irq", {31'h0, irq}, 32'h1);
		wr(8'h2c, 32'h1);
		@(posedge clk);
		check("irq", {31'h0, irq}, 32'h0);
		wr(8'h28, 32'h10000);
		@(posedge clk);
		check("irq", {31'h0, irq}, 32'h1);
		wr(8'h2c, 32'hffffffff);
		wr(8'h24, 32'hffffffff);
		// an event held across the clearing write must win
		event_pulse <= 24'h000001;
		wr(8'h2c, 32'h1);
		event_pulse <= 24'h0;
		rdc("flag kept", 8'h2c, 32'h00000001);
		wr(8'h2c, 32'h1);
		rdc("flags", 8'h2c, 32'h0);
	endtask

	task automatic t_protect();
		wr(8'h28, 32'h2);
		peripheral_write_protect <= 1'b1;
		wr(8'h28, 32'hffffff);
		wr(8'h24, 32'h2);
		rdc("protected", 8'h28, 32'h2);
		peripheral_write_protect <= 1'b0;
		wr(8'h24, 32'h2);
		rdc("set view", 8'h28, 32'h0);
	endtask

	task automatic t_unmapped();
		rdc("unmapped", 8'h30, 32'h0);
		wr(8'h30, 32'hffffffff);
		rdc("set view", 8'h28, 32'h0);
	endtask

	// a mid-run reset must drop every enable, flag and the level
	task automatic t_rerun();
		wr(8'h28, 32'h000ffc0f);
		event_pulse <= 24'h000001;
		@(posedge clk);
		event_pulse <= 24'h0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("irq_enable", {8'h0, irq_enable}, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
		rdc("flags", 8'h2c, 32'h0);
		rdc("clear view", 8'h24, 32'h0);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 8'h0;
		byteenable = 4'h0;
		writedata = 32'h0;
		peripheral_write_protect = 1'b0;
		event_pulse = 24'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_bits();
		t_bytes();
		t_irq();
		t_protect();
		t_unmapped();
		t_rerun();
		stop_test();
	end
endmodule
